/* File: cpu_regs_params.svh */
// Purpose: Constants for the programmer-visible register set.
// Assumes: One bus clock, synchronous active-high reset.
// Notes:   Included by the cpu_regs design module only; the package does not include it.
//
// What this block does
// - Eight-bit result register feeds ALU, loads, stores.
// - Reset leaves the result register unchanged.
// - Index pointer is upper byte over lower byte.
// - Indexed addressing uses full sixteen-bit pointer.
// - Legacy instructions touch only lower pointer byte.
// - Reset clears the upper pointer byte.
// - Reset leaves the lower pointer byte unchanged.
// - Lower byte supports unary ALU operations.
// - Stack pointer addresses next free stack location.
// - Calls and interrupts save state on stack.
// - Stack adjust adds sign-extended eight-bit immediate.
// - Reset loads stack pointer with 0x00ff.
// - Stack low reload changes only low byte.
// - CPU registers have no memory addresses.
// - One linear 64-Kbyte space, sixteen-bit addresses.
// - Direct addresses confined to page zero.
// - Branches add signed eight-bit offset to fetch pointer.
// - Reset loads fetch pointer from vector bytes.
// - Fetch pointer advances unless flow changes.
// - Condition flag bits 6 and 5 read one.
`ifndef CPU_REGS_PARAMS_SVH
`define CPU_REGS_PARAMS_SVH

`define SP_RESET         16'h00ff
`define SP_LOW_RELOAD    8'hff
`define IDX_HI_RESET     8'h00
`define VEC_ADDR_HI      16'hfffe
`define VEC_ADDR_LO      16'hffff
`define FLAGS_ONE_MASK   8'h60
`define FLAGS_RESET      8'h68
`define FLAG_BIT_I       3
`define STACK_PUSH_BYTES 16'h0001

`endif

/* File: cpu_regs_pkg.sv */
// Purpose: Operation codes for the register set.
// Assumes: Codes are driven by the instruction sequencer.
// Notes:   Constants live in the params header.
package cpu_regs_pkg;

  typedef enum logic [3:0] {
    byte_nop   = 4'h0,
    byte_load  = 4'h1,
    byte_clear = 4'h2,
    byte_inc   = 4'h3,
    byte_dec   = 4'h4,
    byte_com   = 4'h5,
    byte_neg   = 4'h6,
    byte_asl   = 4'h7,
    byte_lsr   = 4'h8,
    byte_asr   = 4'h9,
    byte_rol   = 4'ha,
    byte_ror   = 4'hb
  } byte_op_type;

  typedef enum logic [2:0] {
    sp_nop      = 3'h0,
    sp_load     = 3'h1,
    sp_adjust   = 3'h2,
    sp_low_load = 3'h3,
    sp_push     = 3'h4,
    sp_pull     = 3'h5
  } sp_op_type;

  typedef enum logic [2:0] {
    pc_hold     = 3'h0,
    pc_advance  = 3'h1,
    pc_load     = 3'h2,
    pc_branch   = 3'h3,
    pc_vec_hi   = 3'h4,
    pc_vec_lo   = 3'h5
  } pc_op_type;

  typedef enum logic [1:0] {
    addr_index  = 2'h0,
    addr_direct = 2'h1,
    addr_ext    = 2'h2,
    addr_stack  = 2'h3
  } addr_mode_type;

  typedef enum logic [1:0] {
    rst_vec_hi   = 2'b00,
    rst_vec_lo   = 2'b01,
    rst_done     = 2'b10
  } rst_state_type;

endpackage : cpu_regs_pkg

/* File: byte_unit.sv */
// Purpose: Eight-bit unary operation unit for a general byte register.
// Assumes: Carry in comes from the condition flags.
// Notes:   Purely combinational; carry out for shifts, rotates, complement and negate.
`timescale 1ns/1ps
`default_nettype none
module byte_unit
  import cpu_regs_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire cpu_regs_pkg::byte_op_type op,
  input  wire logic [WIDTH-1:0]          value,
  input  wire logic [WIDTH-1:0]          load_data,
  input  wire logic                      carry_in,
  output logic [WIDTH-1:0]               result,
  output logic                           carry_out
);
  always_comb begin
    result    = value;
    carry_out = carry_in;
    unique case (op)
      byte_nop:   result = value;
      byte_load:  result = load_data;
      byte_clear: result = '0;
      byte_inc:   result = value + 1'b1;
      byte_dec:   result = value - 1'b1;
      byte_com:   begin
        result    = ~value;
        carry_out = 1'b1;
      end
      byte_neg:   begin
        result    = ~value + 1'b1;
        carry_out = |value;
      end
      byte_asl:   begin
        result    = {value[WIDTH-2:0], 1'b0};
        carry_out = value[WIDTH-1];
      end
      byte_lsr:   begin
        result    = {1'b0, value[WIDTH-1:1]};
        carry_out = value[0];
      end
      byte_asr:   begin
        result    = {value[WIDTH-1], value[WIDTH-1:1]};
        carry_out = value[0];
      end
      byte_rol:   begin
        result    = {value[WIDTH-2:0], carry_in};
        carry_out = value[WIDTH-1];
      end
      byte_ror:   begin
        result    = {carry_in, value[WIDTH-1:1]};
        carry_out = value[0];
      end
      default:    result = value;
    endcase
  end
endmodule : byte_unit
`default_nettype wire

/* File: addr_former.sv */
// Purpose: Forms the sixteen-bit operand address for a memory access.
// Assumes: One linear 64-Kbyte space.
// Notes:   Combinational; the top registers its result.
`timescale 1ns/1ps
`default_nettype none
module addr_former
  import cpu_regs_pkg::*;
(
  input  wire cpu_regs_pkg::addr_mode_type mode,
  input  wire logic [15:0]                 index_ptr,
  input  wire logic [15:0]                 stack_ptr,
  input  wire logic [15:0]                 operand,
  output logic [15:0]                      addr
);
  always_comb begin
    unique case (mode)
      addr_index:  addr = index_ptr + operand;
      addr_direct: addr = {8'h00, operand[7:0]};
      addr_ext:    addr = operand;
      addr_stack:  addr = stack_ptr + operand;
    endcase
  end
endmodule : addr_former
`default_nettype wire

/* File: cpu_regs.sv */
// Purpose: Programmer-visible CPU registers: result, index, stack,
//          fetch pointer and condition flags.
// Assumes: Sequencer asserts write strobes on the writing edge of each
//          instruction; memory read data arrives with the vector strobes.
// Notes:   No register here has a memory address.
`timescale 1ns/1ps
`default_nettype none
`include "cpu_regs_params.svh"
module cpu_regs
  import cpu_regs_pkg::*;
(
  input  wire logic                        sys_clk,
  input  wire logic                        reset,
  input  wire cpu_regs_pkg::byte_op_type   acc_op,
  input  wire logic [7:0]                  acc_data,
  input  wire cpu_regs_pkg::byte_op_type   idx_lo_op,
  input  wire logic [7:0]                  idx_lo_data,
  input  wire logic                        idx_hi_load,
  input  wire logic [7:0]                  idx_hi_data,
  input  wire logic                        idx_word_load,
  input  wire logic [15:0]                 idx_word_data,
  input  wire cpu_regs_pkg::sp_op_type     sp_op,
  input  wire logic [15:0]                 sp_data,
  input  wire cpu_regs_pkg::pc_op_type     pc_op,
  input  wire logic [15:0]                 pc_data,
  input  wire logic [7:0]                  mem_rdata,
  input  wire logic                        flags_load,
  input  wire logic [7:0]                  flags_data,
  input  wire logic                        carry_use_unit,
  input  wire cpu_regs_pkg::addr_mode_type addr_mode,
  input  wire logic [15:0]                 addr_operand,
  output logic [7:0]                       accumulator,
  output logic [15:0]                      index_pointer,
  output logic [15:0]                      stack_pointer,
  output logic [15:0]                      fetch_pointer,
  output logic [7:0]                       condition_flags,
  output logic [15:0]                      operand_addr,
  output logic [15:0]                      vector_addr,
  output logic                             vector_fetch,
  output logic                             reset_done
);
  logic [7:0]    acc_r;
  logic [7:0]    idx_hi_r;
  logic [7:0]    idx_lo_r;
  logic [15:0]   sp_r;
  logic [15:0]   pc_r;
  logic [7:0]    flags_r;
  logic [15:0]   oaddr_r;
  logic [15:0]   vaddr_r;
  logic          vfetch_r;
  logic          done_r;
  rst_state_type rst_r;
  rst_state_type rst_nxt;

  logic [7:0]    acc_nxt;
  logic [7:0]    idx_lo_nxt;
  logic          acc_carry;
  logic          idx_carry;
  logic [15:0]   sp_nxt;
  logic [15:0]   pc_nxt;
  logic [15:0]   addr_nxt;

  byte_unit #(.WIDTH(8)) acc_unit (
    .op        (acc_op),
    .value     (acc_r),
    .load_data (acc_data),
    .carry_in  (flags_r[0]),
    .result    (acc_nxt),
    .carry_out (acc_carry)
  );

  byte_unit #(.WIDTH(8)) idx_unit (
    .op        (idx_lo_op),
    .value     (idx_lo_r),
    .load_data (idx_lo_data),
    .carry_in  (flags_r[0]),
    .result    (idx_lo_nxt),
    .carry_out (idx_carry)
  );

  addr_former addr_unit (
    .mode      (addr_mode),
    .index_ptr ({idx_hi_r, idx_lo_r}),
    .stack_ptr (sp_r),
    .operand   (addr_operand),
    .addr      (addr_nxt)
  );

  // Result register has no reset branch on purpose.
  always_ff @(posedge sys_clk) begin
    acc_r <= acc_nxt;
  end

  // The lower index byte also carries no reset value.
  always_ff @(posedge sys_clk) begin
    if (idx_word_load) begin
      idx_lo_r <= idx_word_data[7:0];
    end else begin
      idx_lo_r <= idx_lo_nxt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      idx_hi_r <= `IDX_HI_RESET;
    end else if (idx_word_load) begin
      idx_hi_r <= idx_word_data[15:8];
    end else if (idx_hi_load) begin
      idx_hi_r <= idx_hi_data;
    end
  end

  always_comb begin
    unique case (sp_op)
      sp_nop:      sp_nxt = sp_r;
      sp_load:     sp_nxt = sp_data;
      sp_adjust:   sp_nxt = sp_r + {{8{sp_data[7]}}, sp_data[7:0]};
      sp_low_load: sp_nxt = {sp_r[15:8], `SP_LOW_RELOAD};
      sp_push:     sp_nxt = sp_r - `STACK_PUSH_BYTES;
      sp_pull:     sp_nxt = sp_r + `STACK_PUSH_BYTES;
      default:     sp_nxt = sp_r;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sp_r <= `SP_RESET;
    end else begin
      sp_r <= sp_nxt;
    end
  end

  // Reset vector fetch: high byte then low byte, then hand over.
  always_comb begin
    rst_nxt = rst_r;
    unique case (rst_r)
      rst_vec_hi: rst_nxt = rst_vec_lo;
      rst_vec_lo: rst_nxt = rst_done;
      rst_done:   rst_nxt = rst_done;
      default:    rst_nxt = rst_vec_hi;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rst_r <= rst_vec_hi;
    end else begin
      rst_r <= rst_nxt;
    end
  end

  // Registered copy of the hand-over state so the output is a flip-flop.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      done_r <= 1'b0;
    end else begin
      done_r <= (rst_nxt == rst_done);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      vaddr_r  <= `VEC_ADDR_HI;
      vfetch_r <= 1'b1;
    end else begin
      vaddr_r  <= `VEC_ADDR_LO;
      vfetch_r <= (rst_r == rst_vec_hi);
    end
  end

  always_comb begin
    unique case (pc_op)
      pc_hold:    pc_nxt = pc_r;
      pc_advance: pc_nxt = pc_r + 16'h0001;
      pc_load:    pc_nxt = pc_data;
      pc_branch:  pc_nxt = pc_r + {{8{pc_data[7]}}, pc_data[7:0]};
      pc_vec_hi:  pc_nxt = {mem_rdata, pc_r[7:0]};
      pc_vec_lo:  pc_nxt = {pc_r[15:8], mem_rdata};
      default:    pc_nxt = pc_r;
    endcase
  end

  // During the vector fetch the sequencer's request is ignored.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pc_r <= 16'h0000;
    end else if (rst_r == rst_vec_hi) begin
      pc_r <= {mem_rdata, pc_r[7:0]};
    end else if (rst_r == rst_vec_lo) begin
      pc_r <= {pc_r[15:8], mem_rdata};
    end else begin
      pc_r <= pc_nxt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      flags_r <= `FLAGS_RESET;
    end else if (flags_load) begin
      flags_r <= flags_data | `FLAGS_ONE_MASK;
    end else if (carry_use_unit) begin
      flags_r <= {flags_r[7:1], idx_lo_op != byte_nop ? idx_carry
                                                      : acc_carry};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      oaddr_r <= 16'h0000;
    end else begin
      oaddr_r <= addr_nxt;
    end
  end

  // Outputs straight from flip-flops; none is decoded from an address.
  assign accumulator     = acc_r;
  assign index_pointer   = {idx_hi_r, idx_lo_r};
  assign stack_pointer   = sp_r;
  assign fetch_pointer   = pc_r;
  assign condition_flags = flags_r;
  assign operand_addr    = oaddr_r;
  assign vector_addr     = vaddr_r;
  assign vector_fetch    = vfetch_r;
  assign reset_done      = done_r;
endmodule : cpu_regs
`default_nettype wire

/* File: cpu_regs_assertions.sv */
// Purpose: Port checks for the register set.
// Assumes: Ops are taken on each rising sys_clk edge.
// Notes:   Attached to cpu_regs by bind.
`timescale 1ns/1ps
`default_nettype none
module cpu_regs_assertions
  import cpu_regs_pkg::*;
(
  input wire logic                        sys_clk,
  input wire logic                        reset,
  input wire cpu_regs_pkg::byte_op_type   acc_op,
  input wire cpu_regs_pkg::byte_op_type   idx_lo_op,
  input wire logic                        idx_hi_load,
  input wire logic                        idx_word_load,
  input wire logic [15:0]                 idx_word_data,
  input wire cpu_regs_pkg::sp_op_type     sp_op,
  input wire logic [15:0]                 sp_data,
  input wire cpu_regs_pkg::addr_mode_type addr_mode,
  input wire logic [15:0]                 addr_operand,
  input wire logic [7:0]                  accumulator,
  input wire logic [15:0]                 index_pointer,
  input wire logic [15:0]                 stack_pointer,
  input wire logic [7:0]                  condition_flags,
  input wire logic [15:0]                 operand_addr
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic        acc_ok_r = 1'b0;
  logic [15:0] stk_sum;
  logic [15:0] ix_sum;
  assign stk_sum = stack_pointer + {{8{sp_data[7]}}, sp_data[7:0]};
  assign ix_sum = index_pointer + addr_operand;
  // Marks that the result register holds a known value worth keeping.
  always_ff @(posedge sys_clk) begin
    if (acc_op == byte_load) begin
      acc_ok_r <= 1'b1;
    end
  end
  chk_stack_reset: assert property (disable iff (1'b0)
    reset |=> stack_pointer == 16'h00ff) else $error("stack not 00ff");
  chk_upper_clear: assert property (disable iff (1'b0)
    reset |=> index_pointer[15:8] == 8'h00) else $error("upper not 00");
  chk_acc_kept: assert property (disable iff (1'b0)
    reset && acc_ok_r && acc_op == byte_nop |=> $stable(accumulator))
    else $error("result changed by reset");
  chk_flag_ones: assert property (
    condition_flags[6:5] == 2'b11) else $error("flag bits 6:5 not set");
  chk_stack_adjust: assert property (
    sp_op == sp_adjust |=> stack_pointer == $past(stk_sum))
    else $error("stack adjust wrong");
  chk_stack_low: assert property (
    sp_op == sp_low_load |=> stack_pointer[7:0] == 8'hff &&
    $stable(stack_pointer[15:8])) else $error("stack low reload wrong");
  chk_word_load: assert property (
    idx_word_load |=> index_pointer == $past(idx_word_data))
    else $error("index word load wrong");
  chk_lower_only: assert property (
    idx_lo_op != byte_nop && !idx_word_load && !idx_hi_load |=>
    $stable(index_pointer[15:8])) else $error("upper byte disturbed");
  chk_direct_page: assert property (
    addr_mode == addr_direct |=> operand_addr[15:8] == 8'h00 &&
    operand_addr[7:0] == $past(addr_operand[7:0]))
    else $error("direct address off page");
  chk_index_base: assert property (
    addr_mode == addr_index |=> operand_addr == $past(ix_sum))
    else $error("indexed address wrong");
  cover property (sp_op == sp_adjust);
  cover property (reset && acc_ok_r);
  cover property (idx_word_load);
endmodule : cpu_regs_assertions
bind cpu_regs cpu_regs_assertions u_chk (
  .sys_clk(sys_clk), .reset(reset), .acc_op(acc_op),
  .idx_lo_op(idx_lo_op), .idx_hi_load(idx_hi_load),
  .idx_word_load(idx_word_load), .idx_word_data(idx_word_data),
  .sp_op(sp_op), .sp_data(sp_data), .addr_mode(addr_mode),
  .addr_operand(addr_operand), .accumulator(accumulator),
  .index_pointer(index_pointer), .stack_pointer(stack_pointer),
  .condition_flags(condition_flags), .operand_addr(operand_addr)
);
`default_nettype wire

/* File: vector_mem.sv */
// Purpose: Memory side that answers the reset vector fetch.
// Assumes: Read data follows the vector address without delay.
// Notes:   Other addresses return a byte that flips every cycle.
`timescale 1ns/1ps
`default_nettype none
module vector_mem #(
  parameter logic [15:0] START = 16'h1234
) (
  input  wire logic        sys_clk,
  input  wire logic [15:0] vector_addr,
  output logic [7:0]       mem_rdata
);
  logic [7:0] junk_r = 8'h00;
  always_ff @(posedge sys_clk) begin
    junk_r <= ~junk_r;
  end
  always_comb begin
    mem_rdata = junk_r;
    if (vector_addr == 16'hfffe) begin
      mem_rdata = START[15:8];
    end else if (vector_addr == 16'hffff) begin
      mem_rdata = START[7:0];
    end
  end
endmodule : vector_mem
`default_nettype wire

/* File: cpu_programmer_register_set_tb.sv */
// Purpose: Self-checking bench for the register set.
// Assumes: vector_mem holds the start address 1234.
// Notes:   Scenarios run in turn after one reset; t_keep applies a second reset.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
module cpu_programmer_register_set_tb;
  import cpu_regs_pkg::*;
  logic          sys_clk = 1'b0;
  logic          reset = 1'b1;
  byte_op_type   acc_op = byte_nop;
  byte_op_type   idx_lo_op = byte_nop;
  sp_op_type     sp_op = sp_nop;
  pc_op_type     pc_op = pc_hold;
  addr_mode_type addr_mode = addr_ext;
  logic [7:0]    acc_data = 8'h00;
  logic [7:0]    idx_hi_data = 8'h00;
  logic [7:0]    flags_data = 8'h00;
  logic          idx_hi_load = 1'b0;
  logic          idx_word_load = 1'b0;
  logic          flags_load = 1'b0;
  logic          carry_use_unit = 1'b0;
  logic [15:0]   idx_word_data = 16'h0000;
  logic [15:0]   sp_data = 16'h0000;
  logic [15:0]   pc_data = 16'h0000;
  logic [15:0]   addr_operand = 16'h0000;
  logic [7:0]    mem_rdata, accumulator, condition_flags;
  logic [15:0]   index_pointer, stack_pointer, fetch_pointer;
  logic [15:0]   operand_addr, vector_addr;
  logic          reset_done, vector_fetch;
  int            errors = 0;
  int            total_checks = 0;
  always #12.5 sys_clk = ~sys_clk;
  cpu_regs DUT (.sys_clk(sys_clk), .reset(reset), .acc_op(acc_op),
    .acc_data(acc_data), .idx_lo_op(idx_lo_op),
    .idx_lo_data(idx_word_data[7:0]), .idx_hi_load(idx_hi_load),
    .idx_hi_data(idx_hi_data), .idx_word_load(idx_word_load),
    .idx_word_data(idx_word_data), .sp_op(sp_op), .sp_data(sp_data),
    .pc_op(pc_op), .pc_data(pc_data), .mem_rdata(mem_rdata),
    .flags_load(flags_load), .flags_data(flags_data),
    .carry_use_unit(carry_use_unit), .addr_mode(addr_mode),
    .addr_operand(addr_operand), .accumulator(accumulator),
    .index_pointer(index_pointer), .stack_pointer(stack_pointer),
    .fetch_pointer(fetch_pointer), .condition_flags(condition_flags),
    .operand_addr(operand_addr), .vector_addr(vector_addr),
    .vector_fetch(vector_fetch), .reset_done(reset_done));
  vector_mem u_mem (.sys_clk(sys_clk), .vector_addr(vector_addr),
    .mem_rdata(mem_rdata));
  task automatic tick;
    @(posedge sys_clk);
  endtask : tick
  task automatic stop_test;
    if (errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test
  task automatic do_reset(input int n);
    int k;
    tick;
    reset <= 1'b1;
    repeat (n) tick;
    reset <= 1'b0;
    #1;
    `CHK(vector_fetch, 1'b1)
    `CHK(vector_addr, 16'hfffe)
    for (k = 0; k < 10 && reset_done !== 1'b1; k++) tick;
    #1;
    if (reset_done !== 1'b1) begin
      errors++;
      stop_test;
    end
  endtask : do_reset
  // Each op task drives one cycle, returns to idle, then lets it settle.
  task automatic stk_do(input sp_op_type op, input logic [15:0] d);
    tick;
    sp_op <= op;
    sp_data <= d;
    tick;
    sp_op <= sp_nop;
    #1;
  endtask : stk_do
  task automatic fp_do(input pc_op_type op, input logic [15:0] d);
    tick;
    pc_op <= op;
    pc_data <= d;
    tick;
    pc_op <= pc_hold;
    #1;
  endtask : fp_do
  task automatic ix_do(input byte_op_type op, input logic w,
                       input logic [15:0] d);
    tick;
    idx_lo_op <= op;
    idx_word_load <= w;
    idx_word_data <= d;
    tick;
    idx_lo_op <= byte_nop;
    idx_word_load <= 1'b0;
    #1;
  endtask : ix_do
  task automatic am_do(input addr_mode_type m, input logic [15:0] d);
    tick;
    addr_mode <= m;
    addr_operand <= d;
    tick;
    addr_mode <= addr_ext;
    #1;
  endtask : am_do
  task automatic acc_do(input byte_op_type op, input logic [7:0] d);
    tick;
    acc_op <= op;
    acc_data <= d;
    tick;
    acc_op <= byte_nop;
    #1;
  endtask : acc_do
  task automatic t_reset_state;
    `CHK(stack_pointer, 16'h00ff)
    `CHK(index_pointer[15:8], 8'h00)
    `CHK(fetch_pointer, 16'h1234)
    `CHK(vector_fetch, 1'b0)
    `CHK(vector_addr, 16'hffff)
    `CHK(condition_flags[6:5], 2'b11)
  endtask : t_reset_state
  task automatic t_fetch;
    fp_do(pc_advance, 16'h0000);
    `CHK(fetch_pointer, 16'h1235)
    fp_do(pc_branch, 16'h00fe);
    `CHK(fetch_pointer, 16'h1233)
    fp_do(pc_branch, 16'h0010);
    `CHK(fetch_pointer, 16'h1243)
    fp_do(pc_load, 16'h0200);
    `CHK(fetch_pointer, 16'h0200)
  endtask : t_fetch
  task automatic t_stack;
    stk_do(sp_adjust, 16'h00fe);
    `CHK(stack_pointer, 16'h00fd)
    stk_do(sp_adjust, 16'h0005);
    `CHK(stack_pointer, 16'h0102)
    stk_do(sp_load, 16'h1234);
    stk_do(sp_low_load, 16'h0000);
    `CHK(stack_pointer, 16'h12ff)
    stk_do(sp_push, 16'h0000);
    `CHK(stack_pointer, 16'h12fe)
    stk_do(sp_pull, 16'h0000);
    `CHK(stack_pointer, 16'h12ff)
  endtask : t_stack
  task automatic t_flags;
    tick;
    flags_load <= 1'b1;
    tick;
    flags_load <= 1'b0;
    #1;
    `CHK(condition_flags, 8'h60)
  endtask : t_flags
  task automatic t_index;
    byte_op_type ops[11] = '{byte_neg, byte_asl, byte_lsr, byte_rol,
      byte_ror, byte_com, byte_asr, byte_inc, byte_dec, byte_clear,
      byte_load};
    logic [7:0] lo[11] = '{8'h7f, 8'hfe, 8'h7f, 8'hfe, 8'h7f, 8'h80,
      8'hc0, 8'hc1, 8'hc0, 8'h00, 8'h81};
    ix_do(byte_nop, 1'b1, 16'hc381);
    `CHK(index_pointer, 16'hc381)
    for (int i = 0; i < 11; i++) begin
      ix_do(ops[i], 1'b0, 16'h0081);
      `CHK(index_pointer, {8'hc3, lo[i]})
    end
    am_do(addr_index, 16'h0010);
    `CHK(operand_addr, 16'hc391)
    am_do(addr_direct, 16'h1234);
    `CHK(operand_addr, 16'h0034)
  endtask : t_index
  task automatic t_keep;
    acc_do(byte_load, 8'h5a);
    acc_do(byte_inc, 8'h00);
    `CHK(accumulator, 8'h5b)
    tick;
    idx_hi_load <= 1'b1;
    idx_hi_data <= 8'ha7;
    tick;
    idx_hi_load <= 1'b0;
    #1;
    `CHK(index_pointer, 16'ha781)
    do_reset(1);
    `CHK(accumulator, 8'h5b)
    `CHK(index_pointer, 16'h0081)
    `CHK(stack_pointer, 16'h00ff)
    `CHK(fetch_pointer, 16'h1234)
  endtask : t_keep
  // Rotate takes carry in from the flags; a shift writes carry back.
  task automatic t_carry;
    tick;
    flags_load <= 1'b1;
    flags_data <= 8'h01;
    tick;
    flags_load <= 1'b0;
    #1;
    `CHK(condition_flags, 8'h61)
    ix_do(byte_rol, 1'b0, 16'h0081);
    `CHK(index_pointer, 16'h0003)
    tick;
    carry_use_unit <= 1'b1;
    ix_do(byte_asl, 1'b0, 16'h0081);
    `CHK(index_pointer, 16'h0006)
    `CHK(condition_flags, 8'h60)
    tick;
    carry_use_unit <= 1'b0;
  endtask : t_carry
  initial begin
    do_reset(8);
    t_reset_state;
    t_fetch;
    t_stack;
    t_flags;
    t_index;
    t_keep;
    t_carry;
    stop_test;
  end
endmodule : cpu_programmer_register_set_tb
`default_nettype wire
